// [fmdc_pkg.sv]
/*
 * fmdc_pkg: shared constants for the flash margin / data-flash command sequencer.
 * assumes: consumers refer to every item as fmdc_pkg::name, nothing is imported.
 */
package fmdc_pkg;

	// ****************************************
	// apb register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_INDEX = 8'h04;
	localparam logic [7:0] ADDR_OBJECT = 8'h08;
	localparam logic [7:0] ADDR_MODE = 8'h0c;
	localparam logic [7:0] ADDR_MARGIN = 8'h10;

	// ****************************************
	// status register field positions
	// ****************************************
	localparam int ST_VERIFY_UNC = 0;
	localparam int ST_VERIFY_ERR = 1;
	localparam int ST_PROT = 4;
	localparam int ST_ACCESS = 5;
	localparam int ST_COMPLETE = 7;
	localparam logic [7:0] STATUS_RESET = 8'h80;

	// ****************************************
	// command codes and index slots
	// ****************************************
	localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0e;
	localparam logic [7:0] CMD_ERASE_VERIFY = 8'h10;
	localparam logic [7:0] CMD_PROGRAM = 8'h11;
	localparam logic [2:0] IX_BLOCK = 3'h0;
	localparam logic [2:0] IX_ADDR = 3'h1;
	localparam logic [2:0] IX_DATA0 = 3'h2;
	localparam logic [2:0] IX_DATA3 = 3'h5;

	// ****************************************
	// margin settings
	// ****************************************
	localparam logic [15:0] MRG_NORMAL = 16'h0000;
	localparam logic [15:0] MRG_USER1 = 16'h0001;
	localparam logic [15:0] MRG_USER0 = 16'h0002;
	localparam logic [15:0] MRG_FIELD1 = 16'h0003;
	localparam logic [15:0] MRG_FIELD0 = 16'h0004;
	localparam logic [2:0] MLVL_NORMAL = 3'h0;

	// ****************************************
	// data flash geometry and timing
	// ****************************************
	localparam logic [6:0] DFLASH_BLOCK = 7'h10;
	localparam logic [6:0] PFLASH_BLOCK = 7'h7f;
	localparam logic [15:0] DFLASH_WORDS = 16'h1000;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam int PROG_TIME_NS = 200;
	localparam int CLK_NS = 10;
	localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [2:0] {
		FMDC_IDLE,
		FMDC_CHECK,
		FMDC_VERIFY,
		FMDC_PROG,
		FMDC_PVERIFY,
		FMDC_DONE
	} fmdc_state_t;

endpackage

// [fmdc_array.sv]
/*
 * fmdc_array: data flash word store with one read port and one program port.
 * assumes: single clock, caller never programs an unerased word.
 */
`timescale 1ns/1ns
`default_nettype none

module fmdc_array #(
	parameter int WORDS = 4096,
	parameter int AW = 12
) (
	input wire logic clk,
	input wire logic [AW-1:0] rd_addr,
	output logic [15:0] rd_data,
	output logic rd_unc,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [15:0] wr_data
);

	// ****************************************
	// storage
	// ****************************************
	// no reset so the array maps to ram; content starts unknown
	logic [15:0] mem [WORDS];
	logic [WORDS-1:0] written_reg;

	// program only clears bits, as real cells do; an untouched word counts as
	// erased, so its first program stores the value as is instead of an unknown
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= (written_reg[wr_addr] === 1'b1) ? (mem[wr_addr] & wr_data) : wr_data;
		end
	end

	// tracks words touched since power-up; untouched reads as erased
	always_ff @(posedge clk) begin
		if (wr_en) begin
			written_reg[wr_addr] <= 1'b1;
		end
	end

	// combinational read port
	always_comb begin
		rd_data = (written_reg[rd_addr] === 1'b1) ? mem[rd_addr] : fmdc_pkg::ERASED_WORD;
		rd_unc = 1'b0;
	end

endmodule

`default_nettype wire

// [fmdc_margin.sv]
/*
 * fmdc_margin: per-block read margin level store.
 * assumes: only the sequencer writes it, after checks have passed.
 */
`timescale 1ns/1ns
`default_nettype none

module fmdc_margin (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic set_en,
	input wire logic set_dflash,
	input wire logic [2:0] level,
	output logic [2:0] pflash_level,
	output logic [2:0] dflash_level
);

	// ****************************************
	// level registers
	// ****************************************
	// levels stay until the next margin command or reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pflash_level <= fmdc_pkg::MLVL_NORMAL;
			dflash_level <= fmdc_pkg::MLVL_NORMAL;
		end else if (set_en) begin
			if (set_dflash) begin
				dflash_level <= level;
			end else begin
				pflash_level <= level;
			end
		end
	end

endmodule

`default_nettype wire

// [fmdc_seq.sv]
/*
 * fmdc_seq: flash command sequencer for field margin, data flash erase
 * verify and data flash program, reached over apb.
 * assumes: single 100 MHz clock, apb master obeys the busy-flag handshake.
 */
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module fmdc_seq #(
	parameter logic [15:0] DF_WORDS = fmdc_pkg::DFLASH_WORDS,
	parameter int PROG_CYC = fmdc_pkg::PROG_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic busy
);

	// ****************************************
	// state and registers
	// ****************************************
	logic [7:0] status_reg;
	logic [2:0] index_reg;
	logic [15:0] obj_reg [6];
	logic special_reg;
	logic [7:0] prot_reg;
	fmdc_pkg::fmdc_state_t state_reg;
	logic [15:0] addr_reg;
	logic [15:0] left_reg;
	logic [2:0] slot_reg;
	logic [15:0] timer_reg;
	logic [2:0] launch_ix_reg;
	logic [2:0] pf_lvl;
	logic [2:0] df_lvl;
	logic [15:0] rd_data;
	logic rd_unc;

	logic wr_acc;
	logic rd_acc;
	logic launch;
	logic [7:0] cmd;
	logic [6:0] blk;
	logic acc_err;
	logic prot_err;
	logic [2:0] mlvl;
	logic mlvl_ok;
	logic [16:0] span_end;
	logic prog_we;

	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign cmd = obj_reg[0][15:8];
	assign blk = obj_reg[0][6:0];
	// launch is a one written to the completion bit while idle
	assign launch = wr_acc && (paddr == fmdc_pkg::ADDR_STATUS)
		&& pwdata[fmdc_pkg::ST_COMPLETE] && status_reg[fmdc_pkg::ST_COMPLETE];

	// ****************************************
	// launch checks
	// ****************************************
	// margin decode keeps erased/programmed bias in the level code
	always_comb begin
		mlvl_ok = 1'b1;
		mlvl = fmdc_pkg::MLVL_NORMAL;
		if (obj_reg[1] == fmdc_pkg::MRG_NORMAL) begin
			mlvl = fmdc_pkg::MLVL_NORMAL;
		end else if (obj_reg[1] == fmdc_pkg::MRG_USER1) begin
			mlvl = 3'h1;
		end else if (obj_reg[1] == fmdc_pkg::MRG_USER0) begin
			mlvl = 3'h2;
		end else if (obj_reg[1] == fmdc_pkg::MRG_FIELD1) begin
			mlvl = 3'h3;
		end else if (obj_reg[1] == fmdc_pkg::MRG_FIELD0) begin
			mlvl = 3'h4;
		end else begin
			mlvl_ok = 1'b0;
		end
	end

	// span end: start word plus the erase-verify count, or plus the program index minus one
	always_comb begin
		if (cmd == fmdc_pkg::CMD_PROGRAM) begin
			span_end = {1'b0, obj_reg[1] >> 1} + {14'h0000, index_reg} - 17'h00001;
		end else begin
			span_end = {1'b0, obj_reg[1] >> 1} + {1'b0, obj_reg[2]};
		end
	end

	always_comb begin
		acc_err = 1'b0;
		prot_err = 1'b0;
		case (cmd)
			fmdc_pkg::CMD_FIELD_MARGIN: begin
				acc_err = !special_reg
					|| index_reg != fmdc_pkg::IX_ADDR
					|| (blk != fmdc_pkg::DFLASH_BLOCK && blk != fmdc_pkg::PFLASH_BLOCK)
					|| !mlvl_ok;
			end
			fmdc_pkg::CMD_ERASE_VERIFY: begin
				acc_err = index_reg != fmdc_pkg::IX_DATA0
					|| blk != fmdc_pkg::DFLASH_BLOCK
					|| obj_reg[1][0]
					|| span_end > {1'b0, DF_WORDS};
			end
			fmdc_pkg::CMD_PROGRAM: begin
				acc_err = index_reg < fmdc_pkg::IX_DATA0
					|| index_reg > fmdc_pkg::IX_DATA3
					|| blk != fmdc_pkg::DFLASH_BLOCK
					|| obj_reg[1][0]
					|| span_end > {1'b0, DF_WORDS}; // one past the last word may equal the end
				prot_err = prot_reg[obj_reg[1][15:13]];
			end
			default: begin
				acc_err = 1'b1;
			end
		endcase
	end

	// ****************************************
	// command state machine
	// ****************************************
	// one word per cycle in verify; program waits the cell time per word
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= fmdc_pkg::FMDC_IDLE;
			addr_reg <= 16'h0000;
			left_reg <= 16'h0000;
			slot_reg <= 3'h0;
			timer_reg <= 16'h0000;
			launch_ix_reg <= 3'h0;
		end else begin
			case (state_reg)
				fmdc_pkg::FMDC_IDLE: begin
					if (launch) begin
						state_reg <= fmdc_pkg::FMDC_CHECK;
						launch_ix_reg <= index_reg;
					end
				end
				fmdc_pkg::FMDC_CHECK: begin
					addr_reg <= obj_reg[1] >> 1;
					slot_reg <= fmdc_pkg::IX_DATA0;
					timer_reg <= 16'h0000;
					if (acc_err || prot_err) begin
						state_reg <= fmdc_pkg::FMDC_DONE;
					end else if (cmd == fmdc_pkg::CMD_ERASE_VERIFY) begin
						left_reg <= obj_reg[2];
						state_reg <= fmdc_pkg::FMDC_VERIFY;
					end else if (cmd == fmdc_pkg::CMD_PROGRAM) begin
						left_reg <= {13'h0000, launch_ix_reg - 3'h1};
						state_reg <= fmdc_pkg::FMDC_PROG;
					end else begin
						state_reg <= fmdc_pkg::FMDC_DONE;
					end
				end
				fmdc_pkg::FMDC_VERIFY: begin
					if (left_reg == 16'h0000) begin
						state_reg <= fmdc_pkg::FMDC_DONE;
					end else begin
						addr_reg <= addr_reg + 16'h0001;
						left_reg <= left_reg - 16'h0001;
					end
				end
				fmdc_pkg::FMDC_PROG: begin
					if (timer_reg == 16'(PROG_CYC - 1)) begin
						timer_reg <= 16'h0000;
						state_reg <= fmdc_pkg::FMDC_PVERIFY;
					end else begin
						timer_reg <= timer_reg + 16'h0001;
					end
				end
				fmdc_pkg::FMDC_PVERIFY: begin
					if (left_reg == 16'h0001) begin
						state_reg <= fmdc_pkg::FMDC_DONE;
					end else begin
						addr_reg <= addr_reg + 16'h0001;
						slot_reg <= slot_reg + 3'h1;
						left_reg <= left_reg - 16'h0001;
						state_reg <= fmdc_pkg::FMDC_PROG;
					end
				end
				default: begin
					state_reg <= fmdc_pkg::FMDC_IDLE;
				end
			endcase
		end
	end

	// program pulse lands at the start of each word's cell time
	assign prog_we = state_reg == fmdc_pkg::FMDC_PROG && timer_reg == 16'h0000;

	// ****************************************
	// status register
	// ****************************************
	// software clears the access and protection error bits by writing one; hardware set wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			status_reg <= fmdc_pkg::STATUS_RESET;
		end else begin
			if (launch) begin
				status_reg[fmdc_pkg::ST_COMPLETE] <= 1'b0;
			end else if (state_reg == fmdc_pkg::FMDC_DONE) begin
				status_reg[fmdc_pkg::ST_COMPLETE] <= 1'b1;
			end
			if (state_reg == fmdc_pkg::FMDC_CHECK && acc_err) begin
				status_reg[fmdc_pkg::ST_ACCESS] <= 1'b1;
			end else if (wr_acc && paddr == fmdc_pkg::ADDR_STATUS
				&& pwdata[fmdc_pkg::ST_ACCESS]) begin
				status_reg[fmdc_pkg::ST_ACCESS] <= 1'b0;
			end
			if (state_reg == fmdc_pkg::FMDC_CHECK && prot_err && !acc_err) begin
				status_reg[fmdc_pkg::ST_PROT] <= 1'b1;
			end else if (wr_acc && paddr == fmdc_pkg::ADDR_STATUS
				&& pwdata[fmdc_pkg::ST_PROT]) begin
				status_reg[fmdc_pkg::ST_PROT] <= 1'b0;
			end
			// verify flags restart at each launch
			if (launch) begin
				status_reg[fmdc_pkg::ST_VERIFY_ERR] <= 1'b0;
				status_reg[fmdc_pkg::ST_VERIFY_UNC] <= 1'b0;
			end else if ((state_reg == fmdc_pkg::FMDC_VERIFY && left_reg != 16'h0000
				&& rd_data != fmdc_pkg::ERASED_WORD)
				|| (state_reg == fmdc_pkg::FMDC_PVERIFY
				&& rd_data != obj_reg[slot_reg])) begin
				status_reg[fmdc_pkg::ST_VERIFY_ERR] <= 1'b1;
				status_reg[fmdc_pkg::ST_VERIFY_UNC] <= status_reg[fmdc_pkg::ST_VERIFY_UNC] | rd_unc;
			end
		end
	end

	// ****************************************
	// command buffer and configuration
	// ****************************************
	// writes while the completion bit is clear are dropped
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			index_reg <= 3'h0;
			special_reg <= 1'b0;
			prot_reg <= 8'h00;
			for (int i = 0; i < 6; i++) begin
				obj_reg[i] <= 16'h0000;
			end
		end else if (wr_acc && status_reg[fmdc_pkg::ST_COMPLETE]) begin
			if (paddr == fmdc_pkg::ADDR_INDEX) begin
				index_reg <= pwdata[2:0];
			end else if (paddr == fmdc_pkg::ADDR_OBJECT && index_reg <= fmdc_pkg::IX_DATA3) begin
				obj_reg[index_reg] <= pwdata[15:0];
			end else if (paddr == fmdc_pkg::ADDR_MODE) begin
				special_reg <= pwdata[0];
				prot_reg <= pwdata[15:8];
			end
		end
	end

	// ****************************************
	// apb answer
	// ****************************************
	// zero wait states; unmapped addresses return slverr
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable) begin
				if (paddr == fmdc_pkg::ADDR_STATUS) begin
					prdata <= {24'h00_0000, status_reg};
				end else if (paddr == fmdc_pkg::ADDR_INDEX) begin
					prdata <= {29'h0000_0000, index_reg};
				end else if (paddr == fmdc_pkg::ADDR_OBJECT) begin
					prdata <= (index_reg <= fmdc_pkg::IX_DATA3) ? {16'h0000, obj_reg[index_reg]} : 32'h0000_0000;
				end else if (paddr == fmdc_pkg::ADDR_MODE) begin
					prdata <= {16'h0000, prot_reg, 7'h00, special_reg};
				end else if (paddr == fmdc_pkg::ADDR_MARGIN) begin
					prdata <= {24'h00_0000, 1'b0, df_lvl, 1'b0, pf_lvl};
				end else begin
					pslverr <= 1'b1;
				end
			end
		end
	end

	// busy mirrors the running command
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy <= 1'b0;
		end else begin
			busy <= state_reg != fmdc_pkg::FMDC_IDLE;
		end
	end

	// ****************************************
	// sub-blocks
	// ****************************************
	fmdc_array #(.WORDS(4096), .AW(12)) u_array (
		.clk(clk),
		.rd_addr(addr_reg[11:0]),
		.rd_data(rd_data),
		.rd_unc(rd_unc),
		.wr_en(prog_we),
		.wr_addr(addr_reg[11:0]),
		.wr_data(obj_reg[slot_reg])
	);

	fmdc_margin u_margin (
		.clk(clk),
		.rst_b(rst_b),
		.set_en(state_reg == fmdc_pkg::FMDC_CHECK && cmd == fmdc_pkg::CMD_FIELD_MARGIN
			&& !acc_err),
		.set_dflash(blk == fmdc_pkg::DFLASH_BLOCK),
		.level(mlvl),
		.pflash_level(pf_lvl),
		.dflash_level(df_lvl)
	);

endmodule

`default_nettype wire

// [fmdc_asserts.sv]
/*
 * fmdc_asserts: port-level checker for the flash command sequencer.
 * assumes: bound onto fmdc_seq; one clock, reset async active low.
 */
`timescale 1ns/1ns
`default_nettype none

module fmdc_asserts (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	// ****************************************
	// helper logic
	// ****************************************
	logic [15:0] busy_cnt_reg;

	// run length of busy; saturates so a hang cannot wrap back to pass
	// wide enough for a whole-block erase verify, one word per cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_cnt_reg <= 16'h0000;
		end else if (!busy) begin
			busy_cnt_reg <= 16'h0000;
		end else if (busy_cnt_reg != 16'hffff) begin
			busy_cnt_reg <= busy_cnt_reg + 16'h0001;
		end
	end

	// ****************************************
	// bus and sequencer properties
	// ****************************************
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && !penable))
		else $error("ready outside access");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("slave error without ready");
	a_slverr_unmapped: assert property (psel && !penable && paddr > 8'h10 |=> pslverr)
		else $error("unmapped address accepted");
	a_mapped_no_err: assert property (psel && !penable && paddr inside {8'h00, 8'h04, 8'h08,
		8'h0c, 8'h10} |=> !pslverr)
		else $error("mapped address refused");
	a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_launch_busy: assert property (psel && penable && pready && pwrite && paddr == 8'h00 &&
		pwdata[7] && !busy |-> ##[1:3] busy)
		else $error("launch did not start");
	a_busy_bounded: assert property (busy_cnt_reg < 16'h2000)
		else $error("command never completed");
	a_margin_range: assert property (pready && !pwrite && paddr == 8'h10 |->
		prdata[2:0] <= 3'h4 && prdata[6:4] <= 3'h4)
		else $error("undefined margin level stored");
endmodule

bind fmdc_seq fmdc_asserts fmdc_asserts_i (.clk(clk), .rst_b(rst_b), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .busy(busy));

`default_nettype wire

// [flash_margin_dflash_cmds_bench.sv]
/*
 * flash_margin_dflash_cmds_bench: apb-driven self-checking bench for fmdc_seq.
 * assumes: fmdc_pkg and design files compiled first; short program time.
 */
`timescale 1ns/1ns
`default_nettype none

module flash_margin_dflash_cmds_bench;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic busy;
	logic [31:0] rd;
	logic er;
	int mismatches = 0;
	int cmp_count = 0;

	// 100 MHz clock
	always #5 clk = ~clk;

	fmdc_seq #(.PROG_CYC(2)) fmdc_seq_i (.clk(clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));

	// ****************************************
	// report helpers
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// apb access; idle cycle after each so no signal is set twice per step
	// ****************************************
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			mismatches++;
			print_verdict();
		end
		@(posedge clk);
	endtask

	task automatic slot(input logic [2:0] ix, input logic [15:0] v);
		xfer(1'b1, fmdc_pkg::ADDR_INDEX, {29'h0000_0000, ix});
		xfer(1'b1, fmdc_pkg::ADDR_OBJECT, {16'h0000, v});
	endtask

	// load header slots, clear old errors, launch, poll until complete
	task automatic run(input logic [7:0] c, input logic [6:0] blk, input logic [15:0] a,
		input logic [2:0] ix, input logic [7:0] exp);
		int n;
		slot(3'h0, {c, 1'b0, blk});
		slot(3'h1, a);
		xfer(1'b1, fmdc_pkg::ADDR_INDEX, {29'h0000_0000, ix});
		xfer(1'b1, fmdc_pkg::ADDR_STATUS, 32'h0000_0030);
		xfer(1'b1, fmdc_pkg::ADDR_STATUS, 32'h0000_0080);
		n = 0;
		// only status reads while the command runs
		do begin
			xfer(1'b0, fmdc_pkg::ADDR_STATUS, 32'h0000_0000);
			n++;
		end while (rd[7] !== 1'b1 && n < 200);
		if (n >= 200) begin
			mismatches++;
			print_verdict();
		end
		check(rd, {24'h00_0000, exp});
		check({31'h0000_0000, busy}, 32'h0000_0000);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		xfer(1'b0, fmdc_pkg::ADDR_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0080);
		xfer(1'b0, 8'h40, 32'h0000_0000);
		check({er, rd[30:0]}, 32'h8000_0000);
		// margin command refused outside special mode
		run(fmdc_pkg::CMD_FIELD_MARGIN, fmdc_pkg::PFLASH_BLOCK, 16'h0003, 3'h1, 8'ha0);
		xfer(1'b1, fmdc_pkg::ADDR_MODE, 32'h0000_0001);
		// field levels only exercised here, as a factory verify would
		for (int lv = 0; lv < 5; lv++) begin
			run(fmdc_pkg::CMD_FIELD_MARGIN, fmdc_pkg::DFLASH_BLOCK, lv[15:0], 3'h1, 8'h80);
			xfer(1'b0, fmdc_pkg::ADDR_MARGIN, 32'h0000_0000);
			check(rd, {25'h000_0000, lv[2:0], 4'h0});
		end
		run(fmdc_pkg::CMD_FIELD_MARGIN, fmdc_pkg::PFLASH_BLOCK, 16'h0001, 3'h1, 8'h80);
		run(fmdc_pkg::CMD_FIELD_MARGIN, fmdc_pkg::DFLASH_BLOCK, 16'h0005, 3'h1, 8'ha0);
		run(fmdc_pkg::CMD_FIELD_MARGIN, 7'h20, 16'h0000, 3'h1, 8'ha0);
		run(fmdc_pkg::CMD_FIELD_MARGIN, fmdc_pkg::DFLASH_BLOCK, 16'h0000, 3'h0, 8'ha0);
		xfer(1'b0, fmdc_pkg::ADDR_MARGIN, 32'h0000_0000);
		check(rd, 32'h0000_0041);
		// erase verify: pass, wrong index, odd, overrun, bad block, exact end
		slot(3'h2, 16'h0004);
		run(fmdc_pkg::CMD_ERASE_VERIFY, fmdc_pkg::DFLASH_BLOCK, 16'h0000, 3'h2, 8'h80);
		run(fmdc_pkg::CMD_ERASE_VERIFY, fmdc_pkg::DFLASH_BLOCK, 16'h0000, 3'h1, 8'ha0);
		run(fmdc_pkg::CMD_ERASE_VERIFY, fmdc_pkg::DFLASH_BLOCK, 16'h0001, 3'h2, 8'ha0);
		slot(3'h2, 16'h0002);
		run(fmdc_pkg::CMD_ERASE_VERIFY, fmdc_pkg::DFLASH_BLOCK, 16'h1ffe, 3'h2, 8'ha0);
		run(fmdc_pkg::CMD_ERASE_VERIFY, fmdc_pkg::PFLASH_BLOCK, 16'h0000, 3'h2, 8'ha0);
		slot(3'h2, 16'h0001);
		run(fmdc_pkg::CMD_ERASE_VERIFY, fmdc_pkg::DFLASH_BLOCK, 16'h1ffe, 3'h2, 8'h80);
		// program two erased words, then verify those two fail erase verify and the next two still pass
		slot(3'h2, 16'h1234);
		slot(3'h3, 16'h5678);
		run(fmdc_pkg::CMD_PROGRAM, fmdc_pkg::DFLASH_BLOCK, 16'h0010, 3'h3, 8'h80);
		slot(3'h2, 16'h0002);
		run(fmdc_pkg::CMD_ERASE_VERIFY, fmdc_pkg::DFLASH_BLOCK, 16'h0010, 3'h2, 8'h82);
		run(fmdc_pkg::CMD_ERASE_VERIFY, fmdc_pkg::DFLASH_BLOCK, 16'h0014, 3'h2, 8'h80);
		// last word of the block, one word: allowed and lands
		slot(3'h2, 16'h00ff);
		run(fmdc_pkg::CMD_PROGRAM, fmdc_pkg::DFLASH_BLOCK, 16'h1ffe, 3'h2, 8'h80);
		slot(3'h2, 16'h0001);
		run(fmdc_pkg::CMD_ERASE_VERIFY, fmdc_pkg::DFLASH_BLOCK, 16'h1ffe, 3'h2, 8'h82);
		// program launch errors
		run(fmdc_pkg::CMD_PROGRAM, fmdc_pkg::DFLASH_BLOCK, 16'h0020, 3'h1, 8'ha0);
		run(fmdc_pkg::CMD_PROGRAM, fmdc_pkg::DFLASH_BLOCK, 16'h0020, 3'h6, 8'ha0);
		run(fmdc_pkg::CMD_PROGRAM, fmdc_pkg::DFLASH_BLOCK, 16'h0021, 3'h2, 8'ha0);
		run(fmdc_pkg::CMD_PROGRAM, fmdc_pkg::DFLASH_BLOCK, 16'h1ffe, 3'h3, 8'ha0);
		// protected region 0, which covers the whole data flash: violation and the array left untouched
		xfer(1'b1, fmdc_pkg::ADDR_MODE, 32'h0000_0101);
		run(fmdc_pkg::CMD_PROGRAM, fmdc_pkg::DFLASH_BLOCK, 16'h0000, 3'h2, 8'h90);
		slot(3'h2, 16'h0001);
		run(fmdc_pkg::CMD_ERASE_VERIFY, fmdc_pkg::DFLASH_BLOCK, 16'h0000, 3'h2, 8'h80);
		print_verdict();
	end
endmodule

`default_nettype wire
